// [hdl/ram_pkg.sv]
// Shared constants and types for the reliability attribute monitor
package ram_pkg;

   // ==========================================================
   // Attribute table
   localparam int unsigned NUM_ATTR = 8;
   localparam int unsigned ID_W     = 3;
   localparam int unsigned VAL_W    = 8;
   localparam logic [7:0]  VAL_RESET = 8'h64;
   localparam logic [7:0]  THR_MIN   = 8'h01;
   localparam logic [7:0]  THR_MAX   = 8'hFD;
   localparam logic [7:0]  THR_TABLE [0:7] = '{8'h32, 8'h0A, 8'h1E, 8'h05,
                                               8'h3C, 8'h14, 8'h01, 8'hFD};

   // ==========================================================
   // Timing
   localparam longint     CLK_HZ        = 40_000_000;
   localparam longint     MINUTE_S      = 60;
   localparam logic [31:0] MINUTE_CYC   = 32'(CLK_HZ * MINUTE_S);
   localparam logic [5:0] AUTOSAVE_MIN  = 6'h1E;
   localparam logic [7:0] DFLT_STBY_MIN = 8'h6D;

   // ==========================================================
   // Commands and modes
   typedef enum logic [3:0] {
      CMD_IDLE      = 4'h0,
      CMD_IDLE_IMM  = 4'h1,
      CMD_STBY      = 4'h2,
      CMD_STBY_IMM  = 4'h3,
      CMD_SLEEP     = 4'h4,
      CMD_MON_EN    = 4'h5,
      CMD_MON_DIS   = 4'h6,
      CMD_AS_EN     = 4'h7,
      CMD_AS_DIS    = 4'h8,
      CMD_RD_VAL    = 4'h9,
      CMD_RD_THR    = 4'hA
   } ram_cmd_t;

   typedef enum logic [1:0] {
      PWR_ACTIVE  = 2'h0,
      PWR_IDLE    = 2'h1,
      PWR_STANDBY = 2'h3,
      PWR_SLEEP   = 2'h2
   } ram_pwr_t;

   typedef enum logic {
      SEQ_IDLE = 1'b0,
      SEQ_WALK = 1'b1
   } ram_seq_t;

   // Factory thresholds; no write path exists anywhere
   function automatic logic [7:0] ram_thr(input logic [ID_W-1:0] id);
      return THR_TABLE[id];
   endfunction : ram_thr

endpackage : ram_pkg

// [hdl/ram_sync3.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ram_sync3 (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pin_i,
   output logic      level_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // ==========================================================
   // Stages
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Change accepted only once stages two and three agree
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         level_q <= 1'b0;
      else if (s2_q == s3_q)
         level_q <= s3_q;
   end
endmodule : ram_sync3

// [hdl/ram_save_seq.sv]
// Walks every attribute index once per save request
`timescale 1ns/1ps
module ram_save_seq #(
   parameter int unsigned NUM = ram_pkg::NUM_ATTR,
   parameter int unsigned IDW = ram_pkg::ID_W
) (
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic           start_i,
   output logic                busy_q,
   output logic [IDW-1:0]      idx_q,
   output logic                done_q
);
   ram_pkg::ram_seq_t state_q;
   localparam logic [IDW-1:0] LAST = IDW'(NUM - 1);

   // ==========================================================
   // Walk
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ram_pkg::SEQ_IDLE;
         idx_q   <= '0;
         done_q  <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         case (state_q)
            ram_pkg::SEQ_IDLE:
               if (start_i)
               begin
                  state_q <= ram_pkg::SEQ_WALK;
                  idx_q   <= '0;
               end
            ram_pkg::SEQ_WALK:
               if (idx_q == LAST)
               begin
                  state_q <= ram_pkg::SEQ_IDLE;
                  done_q  <= 1'b1;
               end
               else
                  idx_q <= idx_q + 1'b1;
            default:
               state_q <= ram_pkg::SEQ_IDLE;
         endcase
      end
   end

   assign busy_q = (state_q == ram_pkg::SEQ_WALK);
endmodule : ram_save_seq

// [hdl/ram_monitor.sv]
// Reliability attribute monitor: table, compare, power and save control
// How it works
// - Monitoring is off after reset; only the enable command starts it.
// - Each attribute value has its own threshold and is compared to it.
// - Status is negative when monitoring is on and any value is at or below its threshold.
// - All thresholds lie in the range 1 to 253 decimal.
// - Thresholds are constants; no command can change them.
// - Larger value means healthier; smaller means nearer to failure.
// - Every non-emergency head unload saves all values, autosave or not.
// - Standby, standby-immediate, sleep, hard reset, timer expiry are unloads.
// - With autosave on, values also save 30 minutes after the last save.
// - The host may read values and thresholds by command.
// - Inactivity timer moves active or idle into standby on expiry.
`timescale 1ns/1ps
module ram_monitor #(
   parameter int unsigned NUM_ATTR   = ram_pkg::NUM_ATTR,
   parameter int unsigned ID_W       = ram_pkg::ID_W,
   parameter logic [31:0] MINUTE_CYC = ram_pkg::MINUTE_CYC,
   parameter logic [5:0]  AUTOSAVE_MIN = ram_pkg::AUTOSAVE_MIN
) (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            hard_reset_pin,
   input  wire logic            emerg_unload,
   input  wire logic            cmd_valid,
   input  wire logic [3:0]      cmd_op,
   input  wire logic [7:0]      cmd_arg,
   input  wire logic            upd_valid,
   input  wire logic [ID_W-1:0] upd_id,
   input  wire logic [7:0]      upd_value,
   output logic                 monitor_en_q,
   output logic                 autosave_en_q,
   output logic                 rel_neg_q,
   output logic [1:0]           pwr_mode_q,
   output logic                 rd_ack_q,
   output logic [7:0]           rd_data_q,
   output logic                 save_wr_valid_q,
   output logic [ID_W-1:0]      save_wr_id_q,
   output logic [7:0]           save_wr_data_q,
   output logic                 save_done_q
);
   // ==========================================================
   // Declarations
   logic [7:0]      val_q [NUM_ATTR];
   ram_pkg::ram_pwr_t pwr_q;
   logic            cmd_ok;
   ram_pkg::ram_cmd_t op;
   logic            hr_lvl;
   logic            hr_prev_q;
   logic            hr_rise;
   logic [31:0]     pre_q;
   logic            min_tick;
   logic            stby_arm_q;
   logic [7:0]      stby_min_q;
   logic [7:0]      stby_cnt_q;
   logic [7:0]      stby_lim;
   logic            stby_exp;
   logic [5:0]      as_cnt_q;
   logic            as_due;
   logic            unload_ev;
   logic            pend_q;
   logic            seq_busy;
   logic            seq_start;
   logic [ID_W-1:0] seq_idx;
   logic            seq_done;
   logic            neg_d;
   localparam logic [ID_W-1:0] ID_LAST = ID_W'(NUM_ATTR - 1);
   localparam logic [31:0]     PRE_LAST = MINUTE_CYC - 32'h1;

   assign op     = ram_pkg::ram_cmd_t'(cmd_op);
   // Interface is dead in sleep; a hard reset or an emergency unload revives it
   assign cmd_ok = cmd_valid && (pwr_q != ram_pkg::PWR_SLEEP);

   // ==========================================================
   // Hard reset pin
   ram_sync3 u_hr_sync (
      .clk     (clk),
      .rst_n   (rst_n),
      .pin_i   (hard_reset_pin),
      .level_q (hr_lvl)
   );

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         hr_prev_q <= 1'b0;
      else
         hr_prev_q <= hr_lvl;
   end
   assign hr_rise = hr_lvl && !hr_prev_q;

   // ==========================================================
   // Feature enables
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         monitor_en_q  <= 1'b0;
         autosave_en_q <= 1'b0;
      end
      else if (cmd_ok)
      begin
         if (op == ram_pkg::CMD_MON_EN)
            monitor_en_q <= 1'b1;
         else if (op == ram_pkg::CMD_MON_DIS)
            monitor_en_q <= 1'b0;
         if (op == ram_pkg::CMD_AS_EN)
            autosave_en_q <= 1'b1;
         else if (op == ram_pkg::CMD_AS_DIS)
            autosave_en_q <= 1'b0;
      end
   end

   // ==========================================================
   // Attribute table
   // Analysis logic writes only while monitoring; higher is healthier
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_ATTR; i++)
            val_q[i] <= ram_pkg::VAL_RESET;
      end
      else if (upd_valid && monitor_en_q && upd_id <= ID_LAST)
         val_q[upd_id] <= upd_value;
   end

   // ==========================================================
   // Threshold compare
   always_comb
   begin
      neg_d = 1'b0;
      for (int i = 0; i < NUM_ATTR; i++)
         if (val_q[i] <= ram_pkg::ram_thr(ID_W'(i)))
            neg_d = 1'b1;
   end

   // Reported positive while monitoring is off
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rel_neg_q <= 1'b0;
      else
         rel_neg_q <= monitor_en_q && neg_d;
   end

   // ==========================================================
   // Host reads
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_ack_q  <= 1'b0;
         rd_data_q <= '0;
      end
      else
      begin
         rd_ack_q <= cmd_ok && (op == ram_pkg::CMD_RD_VAL ||
                                op == ram_pkg::CMD_RD_THR);
         if (cmd_ok && cmd_arg <= 8'(ID_LAST))
         begin
            if (op == ram_pkg::CMD_RD_VAL)
               rd_data_q <= val_q[ID_W'(cmd_arg)];
            else if (op == ram_pkg::CMD_RD_THR)
               rd_data_q <= ram_pkg::ram_thr(ID_W'(cmd_arg));
         end
         else if (cmd_ok)
            rd_data_q <= '0;
      end
   end

   // ==========================================================
   // Minute prescaler
   // Free-running, so timers carry up to one minute of slack
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pre_q <= '0;
      else if (pre_q == PRE_LAST)
         pre_q <= '0;
      else
         pre_q <= pre_q + 32'h1;
   end
   assign min_tick = (pre_q == PRE_LAST);

   // ==========================================================
   // Standby timer
   assign stby_lim = (stby_min_q == '0) ? ram_pkg::DFLT_STBY_MIN : stby_min_q;
   assign stby_exp = stby_arm_q && min_tick && !cmd_ok &&
                     (pwr_q == ram_pkg::PWR_ACTIVE ||
                      pwr_q == ram_pkg::PWR_IDLE) &&
                     (stby_cnt_q + 8'h1 >= stby_lim);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stby_arm_q <= 1'b0;
         stby_min_q <= '0;
         stby_cnt_q <= '0;
      end
      else if (cmd_ok)
      begin
         stby_cnt_q <= '0;
         if (op == ram_pkg::CMD_IDLE || op == ram_pkg::CMD_STBY)
         begin
            stby_arm_q <= 1'b1;
            stby_min_q <= cmd_arg;
         end
      end
      else if (stby_exp)
         stby_cnt_q <= '0;
      else if (min_tick)
         stby_cnt_q <= stby_cnt_q + 8'h1;
   end

   // ==========================================================
   // Power mode
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pwr_q <= ram_pkg::PWR_IDLE;
      else if (hr_rise)
         pwr_q <= ram_pkg::PWR_STANDBY;
      else if (cmd_ok)
      begin
         case (op)
            ram_pkg::CMD_IDLE,
            ram_pkg::CMD_IDLE_IMM: pwr_q <= ram_pkg::PWR_IDLE;
            ram_pkg::CMD_STBY,
            ram_pkg::CMD_STBY_IMM: pwr_q <= ram_pkg::PWR_STANDBY;
            ram_pkg::CMD_SLEEP:    pwr_q <= ram_pkg::PWR_SLEEP;
            default:               pwr_q <= pwr_q;
         endcase
      end
      else if (stby_exp || emerg_unload)
         pwr_q <= ram_pkg::PWR_STANDBY;
   end
   assign pwr_mode_q = pwr_q;

   // ==========================================================
   // Save triggers
   assign unload_ev = hr_rise || stby_exp ||
                      (cmd_ok && (op == ram_pkg::CMD_STBY ||
                                  op == ram_pkg::CMD_STBY_IMM ||
                                  op == ram_pkg::CMD_SLEEP));
   assign as_due = autosave_en_q && min_tick &&
                   (as_cnt_q + 6'h1 >= AUTOSAVE_MIN);
   assign seq_start = pend_q && !seq_busy;

   // Minutes since last save; restarted whenever a save begins
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         as_cnt_q <= '0;
      else if (seq_start)
         as_cnt_q <= '0;
      else if (min_tick && as_cnt_q < AUTOSAVE_MIN)
         as_cnt_q <= as_cnt_q + 6'h1;
   end

   // New trigger beats the clear; emergency unload never saves
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pend_q <= 1'b0;
      else if (unload_ev || as_due)
         pend_q <= 1'b1;
      else if (seq_start)
         pend_q <= 1'b0;
   end

   ram_save_seq #(
      .NUM (NUM_ATTR),
      .IDW (ID_W)
   ) u_seq (
      .clk     (clk),
      .rst_n   (rst_n),
      .start_i (seq_start),
      .busy_q  (seq_busy),
      .idx_q   (seq_idx),
      .done_q  (seq_done)
   );

   // ==========================================================
   // Media write port
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         save_wr_valid_q <= 1'b0;
         save_wr_id_q    <= '0;
         save_wr_data_q  <= '0;
      end
      else
      begin
         save_wr_valid_q <= seq_busy;
         save_wr_id_q    <= seq_idx;
         save_wr_data_q  <= val_q[seq_idx];
      end
   end
   assign save_done_q = seq_done;

   // ==========================================================
   // Checks
   AST_OFF_AFTER_RESET: assert property (
      @(posedge clk) $rose(rst_n) |-> !monitor_en_q)
      else $error("monitoring on straight after reset");

   AST_EN_CMD: assert property (
      @(posedge clk) disable iff (!rst_n)
      cmd_ok && op == ram_pkg::CMD_MON_EN |=> monitor_en_q)
      else $error("enable command ignored");

   AST_NEG_STATUS: assert property (
      @(posedge clk) disable iff (!rst_n)
      monitor_en_q && neg_d |=> rel_neg_q)
      else $error("negative status missed");

   AST_POS_STATUS: assert property (
      @(posedge clk) disable iff (!rst_n)
      !neg_d |=> !rel_neg_q)
      else $error("false negative status");

   AST_THR_RANGE: assert property (
      @(posedge clk) disable iff (!rst_n)
      $past(cmd_ok && op == ram_pkg::CMD_RD_THR &&
            cmd_arg <= 8'(ID_LAST)) |->
      rd_data_q >= ram_pkg::THR_MIN && rd_data_q <= ram_pkg::THR_MAX)
      else $error("threshold outside valid range");

   AST_THR_FIXED: assert property (
      @(posedge clk) disable iff (!rst_n)
      cmd_ok && op == ram_pkg::CMD_RD_THR && cmd_arg <= 8'(ID_LAST) |=>
      rd_ack_q && rd_data_q == ram_pkg::ram_thr($past(ID_W'(cmd_arg))))
      else $error("threshold read mismatch");

   AST_UNLOAD_SAVE: assert property (
      @(posedge clk) disable iff (!rst_n)
      unload_ev |=> pend_q ##[0:16] seq_busy)
      else $error("unload did not start a save");

   AST_AUTOSAVE: assert property (
      @(posedge clk) disable iff (!rst_n)
      as_due |=> pend_q)
      else $error("autosave deadline missed");

   AST_STBY_EXPIRE: assert property (
      @(posedge clk) disable iff (!rst_n)
      stby_exp && !hr_rise |=> pwr_q == ram_pkg::PWR_STANDBY)
      else $error("timer expiry left mode unchanged");

   AST_SAVE_WALK: assert property (
      @(posedge clk) disable iff (!rst_n)
      seq_start |=> seq_busy && seq_idx == '0)
      else $error("save walk did not start at entry zero");
endmodule : ram_monitor

// [test/ram_host_model.sv]
// Host stand-in that issues monitoring and power commands
`timescale 1ns/1ps
module ram_host_model (
   input  wire logic clk,
   output logic       cmd_valid,
   output logic [3:0] cmd_op,
   output logic [7:0] cmd_arg
);
   // ==========================================================
   // Command issue
   initial
   begin
      cmd_valid = 1'b0;
      cmd_op    = 4'hF;
      cmd_arg   = 8'hFF;
   end

   // Fields inverted when idle so stale values never look valid
   task automatic send(input logic [3:0] op, input logic [7:0] arg);
      @(posedge clk);
      #2;
      cmd_valid = 1'b1;
      cmd_op    = op;
      cmd_arg   = arg;
      @(posedge clk);
      #2;
      cmd_valid = 1'b0;
      cmd_op    = ~op;
      cmd_arg   = ~arg;
   endtask : send
endmodule : ram_host_model

// [test/test_reliability_attribute_monitor.sv]
// Self-checking bench for the reliability attribute monitor
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("mismatch at %0t: %h vs %h", $time, got, exp); \
      end \
   end
module test_reliability_attribute_monitor;
   // ==========================================================
   // Signals
   logic       clk;
   logic       rst_n;
   logic       hard_reset_pin;
   logic       emerg_unload;
   logic       cmd_valid;
   logic [3:0] cmd_op;
   logic [7:0] cmd_arg;
   logic       upd_valid;
   logic [2:0] upd_id;
   logic [7:0] upd_value;
   logic       monitor_en_q;
   logic       autosave_en_q;
   logic       rel_neg_q;
   logic [1:0] pwr_mode_q;
   logic       rd_ack_q;
   logic [7:0] rd_data_q;
   logic       save_wr_valid_q;
   logic [2:0] save_wr_id_q;
   logic [7:0] save_wr_data_q;
   logic       save_done_q;
   int         checks;
   int         miscompares;
   int         words;
   logic [2:0] exp_id;
   logic [7:0] vals [0:7];

   // Short minute keeps timer and autosave runs brief
   ram_monitor #(.MINUTE_CYC(32'h0000000A)) ram_monitor_inst (
      .clk(clk), .rst_n(rst_n), .hard_reset_pin(hard_reset_pin),
      .emerg_unload(emerg_unload), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_arg(cmd_arg), .upd_valid(upd_valid),
      .upd_id(upd_id), .upd_value(upd_value),
      .monitor_en_q(monitor_en_q), .autosave_en_q(autosave_en_q),
      .rel_neg_q(rel_neg_q), .pwr_mode_q(pwr_mode_q),
      .rd_ack_q(rd_ack_q), .rd_data_q(rd_data_q),
      .save_wr_valid_q(save_wr_valid_q), .save_wr_id_q(save_wr_id_q),
      .save_wr_data_q(save_wr_data_q), .save_done_q(save_done_q));

   ram_host_model ram_host_model_inst (
      .clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_arg(cmd_arg));

   // ==========================================================
   // Clock, watchdog, save monitor
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial
   begin
      repeat (6000) @(posedge clk);
      miscompares++;
      $display("mismatch at %0t: watchdog", $time);
      tally_and_finish();
   end

   // Looked at just after the edge, once the new word has settled
   always @(posedge clk)
   begin
      #1;
      if (save_wr_valid_q === 1'b1)
      begin
         `CHK(save_wr_id_q, exp_id)
         `CHK(save_wr_data_q, vals[save_wr_id_q])
         `CHK(save_done_q, (exp_id == 3'h7))
         exp_id = exp_id + 3'h1;
         words++;
      end
   end

   // ==========================================================
   // Helpers
   function automatic logic neg_exp();
      logic n;
      n = 1'b0;
      for (int i = 0; i < 8; i++)
         if (vals[i] <= ram_pkg::THR_TABLE[i])
            n = 1'b1;
      return n;
   endfunction : neg_exp

   task automatic upd(input logic [2:0] id, input logic [7:0] v,
                      input logic take);
      @(posedge clk);
      #2;
      upd_valid = 1'b1;
      upd_id    = id;
      upd_value = v;
      @(posedge clk);
      #2;
      upd_valid = 1'b0;
      if (take)
         vals[id] = v;
      repeat (2) @(posedge clk);
      #2;
   endtask : upd

   // Bounded wait, then a few spare cycles to catch an extra walk
   task automatic wait_save(input int limit);
      for (int i = 0; i < limit && words < 8; i++)
         @(posedge clk);
      repeat (4) @(posedge clk);
      #2;
      `CHK(words, 8)
      words  = 0;
      exp_id = 3'h0;
   endtask : wait_save

   task automatic t_reads();
      for (int i = 0; i < 9; i++)
      begin
         ram_host_model_inst.send(ram_pkg::CMD_RD_THR, 8'(i));
         `CHK(rd_ack_q, 1'b1)
         `CHK(rd_data_q, (i < 8) ? ram_pkg::THR_TABLE[i] : 8'h00)
         if (i < 8)
            `CHK((rd_data_q >= 8'h01) && (rd_data_q <= 8'hFD), 1'b1)
         ram_host_model_inst.send(ram_pkg::CMD_RD_VAL, 8'(i));
         `CHK(rd_data_q, (i < 8) ? vals[i] : 8'h00)
      end
      @(posedge clk);
      #2;
      `CHK(rd_ack_q, 1'b0)
      $display("test reads done");
   endtask : t_reads

   task automatic t_compare();
      `CHK(monitor_en_q, 1'b0)
      `CHK(rel_neg_q, 1'b0)
      `CHK(pwr_mode_q, ram_pkg::PWR_IDLE)
      upd(3'h0, 8'h00, 1'b0);
      `CHK(rel_neg_q, 1'b0)
      ram_host_model_inst.send(ram_pkg::CMD_MON_EN, 8'h00);
      `CHK(monitor_en_q, 1'b1)
      repeat (2) @(posedge clk);
      #2;
      `CHK(rel_neg_q, neg_exp())
      upd(3'h7, 8'hFE, 1'b1);
      `CHK(rel_neg_q, neg_exp())
      upd(3'h0, 8'h32, 1'b1);
      `CHK(rel_neg_q, neg_exp())
      upd(3'h0, 8'h33, 1'b1);
      `CHK(rel_neg_q, neg_exp())
      $display("test compare done");
   endtask : t_compare

   task automatic t_unload();
      ram_host_model_inst.send(ram_pkg::CMD_STBY, 8'h00);
      `CHK(pwr_mode_q, ram_pkg::PWR_STANDBY)
      wait_save(40);
      ram_host_model_inst.send(ram_pkg::CMD_STBY_IMM, 8'h00);
      wait_save(40);
      ram_host_model_inst.send(ram_pkg::CMD_SLEEP, 8'h00);
      `CHK(pwr_mode_q, ram_pkg::PWR_SLEEP)
      wait_save(40);
      ram_host_model_inst.send(ram_pkg::CMD_MON_DIS, 8'h00);
      `CHK(monitor_en_q, 1'b1)
      @(posedge clk);
      #2;
      hard_reset_pin = 1'b1;
      repeat (6) @(posedge clk);
      #2;
      hard_reset_pin = 1'b0;
      wait_save(40);
      `CHK(pwr_mode_q, ram_pkg::PWR_STANDBY)
      ram_host_model_inst.send(ram_pkg::CMD_IDLE_IMM, 8'h00);
      `CHK(pwr_mode_q, ram_pkg::PWR_IDLE)
      @(posedge clk);
      #2;
      emerg_unload = 1'b1;
      @(posedge clk);
      #2;
      emerg_unload = 1'b0;
      repeat (40) @(posedge clk);
      `CHK(words, 0)
      `CHK(pwr_mode_q, ram_pkg::PWR_STANDBY)
      $display("test unload done");
   endtask : t_unload

   task automatic t_timers();
      ram_host_model_inst.send(ram_pkg::CMD_IDLE, 8'h01);
      `CHK(pwr_mode_q, ram_pkg::PWR_IDLE)
      for (int i = 0; i < 60 && pwr_mode_q !== 2'h3; i++)
         @(posedge clk);
      `CHK(pwr_mode_q, ram_pkg::PWR_STANDBY)
      wait_save(40);
      ram_host_model_inst.send(ram_pkg::CMD_AS_EN, 8'h00);
      `CHK(autosave_en_q, 1'b1)
      repeat (260) @(posedge clk);
      `CHK(words, 0)
      wait_save(120);
      ram_host_model_inst.send(ram_pkg::CMD_AS_DIS, 8'h00);
      repeat (400) @(posedge clk);
      `CHK(words, 0)
      $display("test timers done");
   endtask : t_timers

   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // ==========================================================
   // Main sequence
   initial
   begin
      rst_n          = 1'b0;
      hard_reset_pin = 1'b0;
      emerg_unload   = 1'b0;
      upd_valid      = 1'b0;
      upd_id         = 3'h0;
      upd_value      = 8'h00;
      checks         = 0;
      miscompares    = 0;
      words          = 0;
      exp_id         = 3'h0;
      for (int i = 0; i < 8; i++)
         vals[i] = 8'h64;
      repeat (10) @(posedge clk);
      #2;
      rst_n = 1'b1;
      t_compare();
      t_reads();
      t_unload();
      t_timers();
      t_reads();
      tally_and_finish();
   end
endmodule : test_reliability_attribute_monitor
